//--- hdl/roc_conditioner.v
// Relay output conditioner with an AXI4-Lite register slave.
`timescale 1ns/100ps
`include "roc_map.vh"
module roc_conditioner #(
    parameter TICK_CYCLES = `ROC_TICK_CYCLES
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    // Protection signals and acknowledgement sources
    input  wire [6:0]  protSignal,
    input  wire [7:0]  ackSource,
    // Relay coil drive
    output reg         relayDrive,
    // AXI4-Lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Protection signals arrive from other logic of unknown timing, so both groups are resynchronised.
    reg [6:0]  protMeta;
    reg [6:0]  protSync;
    reg [7:0]  ackMeta;
    reg [7:0]  ackSync;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            protMeta <= 7'h00;
            protSync <= 7'h00;
            ackMeta  <= 8'h00;
            ackSync  <= 8'h00;
        end else begin
            protMeta <= protSignal;
            protSync <= protMeta;
            ackMeta  <= ackSource;
            ackSync  <= ackMeta;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [31:0] ctrlReg;
    reg [6:0]  assignReg;
    reg [14:0] holdReg;

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    reg        awHeld;
    reg [3:0]  awAddr;
    reg        wHeld;
    reg [31:0] wData;
    reg [3:0]  wStrb;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;

    wire        awFire  = s_axi_awvalid && s_axi_awready;
    wire        wFire   = s_axi_wvalid && s_axi_wready;
    wire        haveAw  = awHeld || awFire;
    wire        haveW   = wHeld || wFire;
    wire        doWrite = haveAw && haveW;
    wire [3:0]  wrAddr  = awHeld ? awAddr : s_axi_awaddr;
    wire [31:0] wrData  = wHeld ? wData : s_axi_wdata;
    wire [3:0]  wrStrb  = wHeld ? wStrb : s_axi_wstrb;

    reg  [31:0] byteMask;
    integer     b;
    always @* begin
        byteMask = 32'h00000000;
        for (b = 0; b < 4; b = b + 1) begin
            byteMask[b*8 +: 8] = {8{wrStrb[b]}};
        end
    end

    wire [31:0] ctrlNew   = (ctrlReg & ~byteMask) | (wrData & byteMask);
    wire [31:0] holdOld   = {17'h00000, holdReg};
    wire [31:0] holdNew   = (holdOld & ~byteMask) | (wrData & byteMask);
    wire [31:0] assignOld = {25'h0000000, assignReg};
    wire [31:0] assignNew = (assignOld & ~byteMask) | (wrData & byteMask);
    wire        wrMapped  = (wrAddr == `ROC_OFS_CTRL) || (wrAddr == `ROC_OFS_ASSIGN) ||
                            (wrAddr == `ROC_OFS_HOLD) || (wrAddr == `ROC_OFS_STATUS);

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            awHeld       <= 1'b0;
            awAddr       <= 4'h0;
            wHeld        <= 1'b0;
            wData        <= 32'h00000000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ROC_RESP_OKAY;
            ctrlReg      <= `ROC_CTRL_RESET;
            assignReg    <= `ROC_ASSIGN_RESET;
            holdReg      <= `ROC_HOLD_RESET;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMapped ? `ROC_RESP_OKAY : `ROC_RESP_SLVERR;
                case (wrAddr)
                    `ROC_OFS_CTRL: begin
                        ctrlReg <= ctrlNew & `ROC_CTRL_WMASK;
                    end
                    `ROC_OFS_ASSIGN: begin
                        assignReg <= assignNew[6:0];
                    end
                    `ROC_OFS_HOLD: begin
                        // Values beyond 300 s saturate at the top of the range.
                        if (holdNew[31:0] > {17'h00000, `ROC_HOLD_MAX}) begin
                            holdReg <= `ROC_HOLD_MAX;
                        end else begin
                            holdReg <= holdNew[14:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                if (awFire) begin
                    awHeld <= 1'b1;
                    awAddr <= s_axi_awaddr;
                end
                if (wFire) begin
                    wHeld <= 1'b1;
                    wData <= s_axi_wdata;
                    wStrb <= s_axi_wstrb;
                end
            end
        end
    end

    // ****************************************************************
    // Conditioning path
    // ****************************************************************
    wire [6:0] slotInv  = ctrlReg[`ROC_CTRL_INV_MSB:`ROC_CTRL_INV_LSB];
    wire       latchOn  = ctrlReg[`ROC_CTRL_LATCH];
    wire       outInv   = ctrlReg[`ROC_CTRL_OUTINV];
    wire [2:0] ackSel   = ctrlReg[`ROC_CTRL_ACK_MSB:`ROC_CTRL_ACK_LSB];
    wire [6:0] slotTerm;

    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : gSlot
            assign slotTerm[g] = assignReg[g] & (protSync[g] ^ slotInv[g]);
        end
    endgenerate

    wire rawReq   = |slotTerm;
    wire ackPulse = latchOn && ackSync[ackSel];

    reg  latched;
    reg  relayState;
    wire holding;
    wire wantState  = rawReq || latched;
    wire stateApply = (wantState != relayState) && !holding;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latched    <= 1'b0;
            relayState <= 1'b0;
            relayDrive <= 1'b0;
        end else begin
            // Acknowledge wins over a new pick-up in the same cycle, whether or not the request has gone.
            if (!latchOn || ackPulse) begin
                latched <= 1'b0;
            end else if (relayState) begin
                latched <= 1'b1;
            end
            if (stateApply) begin
                relayState <= wantState;
            end
            relayDrive <= (stateApply ? wantState : relayState) ^ outInv;
        end
    end

    roc_hold_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) uHold (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .restart   (stateApply),
        .holdTicks (holdReg),
        .holding   (holding)
    );

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;

    reg [31:0] rdValue;
    reg        rdMapped;
    always @* begin
        rdMapped = 1'b1;
        case (s_axi_araddr)
            `ROC_OFS_CTRL: begin
                rdValue = ctrlReg;
            end
            `ROC_OFS_ASSIGN: begin
                rdValue = {25'h0000000, assignReg};
            end
            `ROC_OFS_HOLD: begin
                rdValue = {17'h00000, holdReg};
            end
            `ROC_OFS_STATUS: begin
                rdValue = {27'h0000000, holding, relayDrive, relayState, latched, rawReq};
            end
            default: begin
                rdValue  = 32'h00000000;
                rdMapped = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `ROC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdValue;
            s_axi_rresp  <= rdMapped ? `ROC_RESP_OKAY : `ROC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

//--- hdl/roc_hold_timer.v
// Minimum hold timer: counts 10 ms ticks after each output state change.
`timescale 1ns/100ps
`include "roc_map.vh"
module roc_hold_timer #(
    parameter TICK_CYCLES = `ROC_TICK_CYCLES
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    // Control
    input  wire        restart,
    input  wire [14:0] holdTicks,
    // Status
    output reg         holding
);
    reg [31:0] preCount;
    reg [14:0] tickCount;

    // A restart with zero hold never raises holding, so a zero setting adds no delay.
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            preCount  <= 32'h00000000;
            tickCount <= 15'h0000;
            holding   <= 1'b0;
        end else if (restart) begin
            preCount  <= 32'h00000000;
            tickCount <= 15'h0000;
            holding   <= (holdTicks != 15'h0000);
        end else if (holding) begin
            if (preCount == TICK_CYCLES - 1) begin
                preCount  <= 32'h00000000;
                tickCount <= tickCount + 15'h0001;
                if (tickCount + 15'h0001 >= holdTicks) begin
                    holding <= 1'b0;
                end
            end else begin
                preCount <= preCount + 32'h00000001;
            end
        end
    end
endmodule

//--- inc/roc_map.vh
// Register map, field positions, reset values and timing constants of the relay output conditioner.
`ifndef ROC_MAP_VH
`define ROC_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ROC_OFS_CTRL     4'h0
`define ROC_OFS_ASSIGN   4'h4
`define ROC_OFS_HOLD     4'h8
`define ROC_OFS_STATUS   4'hC

// ****************************************************************
// Control register fields
// ****************************************************************
`define ROC_CTRL_INV_LSB    0
`define ROC_CTRL_INV_MSB    6
`define ROC_CTRL_LATCH      8
`define ROC_CTRL_OUTINV     9
`define ROC_CTRL_ACK_LSB    12
`define ROC_CTRL_ACK_MSB    14
`define ROC_CTRL_WMASK      32'h00007F7F
`define ROC_CTRL_RESET      32'h00000000

// ****************************************************************
// Assignment register: one enable per slot
// ****************************************************************
`define ROC_ASSIGN_RESET    7'h00

// ****************************************************************
// Hold time: register counts in units of 10 ms, 0..30000
// ****************************************************************
`define ROC_HOLD_MAX        15'h7530
`define ROC_HOLD_RESET      15'h0000
`define ROC_HOLD_UNIT_NS    10000000
`define ROC_CLK_PERIOD_NS   4
`define ROC_TICK_CYCLES     (`ROC_HOLD_UNIT_NS / `ROC_CLK_PERIOD_NS)

// ****************************************************************
// Status register fields
// ****************************************************************
`define ROC_ST_RAW          0
`define ROC_ST_LATCHED      1
`define ROC_ST_STATE        2
`define ROC_ST_DRIVE        3
`define ROC_ST_HOLDING      4

// AXI response codes.
`define ROC_RESP_OKAY       2'h0
`define ROC_RESP_SLVERR     2'h2

`endif

//--- tb/relay_output_conditioner_bench.sv
// Self-checking bench of the relay output conditioner.
`timescale 1ns/100ps
`include "roc_map.vh"
module relay_output_conditioner_bench;
    reg        clk_sys = 1'b0;
    reg        resetn  = 1'b0;
    reg [3:0]  awaddr  = 4'h0;
    reg [3:0]  araddr  = 4'h0;
    reg [31:0] wdata   = 32'h0;
    reg        awvalid = 1'b0;
    reg        wvalid  = 1'b0;
    reg        bready  = 1'b0;
    reg        arvalid = 1'b0;
    reg        rready  = 1'b0;
    reg [6:0]  protReq = 7'h00;
    reg [7:0]  ackReq  = 8'h00;
    wire [6:0] protSignal;
    wire [7:0] ackSource;
    wire [7:0] pickups;
    wire [31:0] rdata;
    wire [1:0] bresp;
    wire [1:0] rresp;
    wire       relayDrive, awready, wready, bvalid, arready, rvalid;
    integer    n_mismatch = 0;
    integer    n_checks = 0;
    integer    cyc = 0;
    integer    i;
    reg [7:0]  p0;

    always #2 clk_sys = ~clk_sys;

    roc_conditioner #(.TICK_CYCLES(4)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .protSignal(protSignal), .ackSource(ackSource),
        .relayDrive(relayDrive), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    roc_field_model u_field (.clk_sys(clk_sys), .protReq(protReq), .ackReq(ackReq),
        .protSignal(protSignal), .ackSource(ackSource), .relayDrive(relayDrive), .pickups(pickups));

    // ****
    // Tasks
    // ****
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask

    // A local flag ends the wait, because bready itself only changes after this time step.
    task wr(input [3:0] a, input [31:0] d);
        integer t;
        reg     busy;
        begin
            @(posedge clk_sys);
            awaddr  <= a;
            wdata   <= d;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            busy = 1'b1;
            t = 0;
            while (busy && t < 50) begin
                @(posedge clk_sys);
                t = t + 1;
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) begin
                    busy = 1'b0;
                    bready <= 1'b0;
                    check({30'h0, bresp}, {30'h0, `ROC_RESP_OKAY});
                end
            end
            if (busy) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: write not answered", $time);
            end
        end
    endtask

    task rd(input [3:0] a, input [31:0] e);
        integer t;
        reg     busy;
        begin
            @(posedge clk_sys);
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
            busy = 1'b1;
            t = 0;
            while (busy && t < 50) begin
                @(posedge clk_sys);
                t = t + 1;
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid) begin
                    busy = 1'b0;
                    rready <= 1'b0;
                    check(rdata, e);
                end
            end
            if (busy) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: read not answered", $time);
            end
        end
    endtask

    task relayIs(input e);
        integer t;
        begin
            t = 0;
            while (relayDrive !== e && t < 40) begin
                @(posedge clk_sys);
                t = t + 1;
            end
            check({31'h0, relayDrive}, {31'h0, e});
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask

    // The whole sequence needs well under 3000 cycles.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end

    // ****
    // Sequence
    // ****
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(`ROC_OFS_CTRL, `ROC_CTRL_RESET);
        rd(`ROC_OFS_ASSIGN, 32'h0);
        rd(`ROC_OFS_HOLD, 32'h0);
        wr(`ROC_OFS_HOLD, 32'h0000FFFF);
        rd(`ROC_OFS_HOLD, {17'h0, `ROC_HOLD_MAX});
        wr(`ROC_OFS_HOLD, 32'h0);
        wr(`ROC_OFS_STATUS, 32'hFFFFFFFF);
        rd(`ROC_OFS_STATUS, 32'h0);
        for (i = 0; i < 7; i = i + 1) begin
            wr(`ROC_OFS_ASSIGN, 32'h1 << i);
            wr(`ROC_OFS_CTRL, 32'h0);
            @(posedge clk_sys) protReq <= ~(7'h01 << i);
            repeat (10) @(posedge clk_sys);
            check({31'h0, relayDrive}, 32'h0);
            @(posedge clk_sys) protReq <= 7'h01 << i;
            relayIs(1'b1);
            wr(`ROC_OFS_CTRL, 32'h1 << i);
            relayIs(1'b0);
            @(posedge clk_sys) protReq <= 7'h00;
            relayIs(1'b1);
        end
        wr(`ROC_OFS_ASSIGN, 32'h1);
        wr(`ROC_OFS_CTRL, 32'h200);
        rd(`ROC_OFS_CTRL, 32'h200);
        relayIs(1'b1);
        @(posedge clk_sys) protReq <= 7'h01;
        relayIs(1'b0);
        @(posedge clk_sys) protReq <= 7'h00;
        wr(`ROC_OFS_CTRL, 32'h0);
        relayIs(1'b0);
        wr(`ROC_OFS_HOLD, 32'h5);
        @(posedge clk_sys) protReq <= 7'h01;
        relayIs(1'b1);
        @(posedge clk_sys) protReq <= 7'h00;
        repeat (9) @(posedge clk_sys);
        check({31'h0, relayDrive}, 32'h1);
        relayIs(1'b0);
        wr(`ROC_OFS_HOLD, 32'h0);
        p0 = pickups;
        for (i = 0; i < 8; i = i + 1) begin
            wr(`ROC_OFS_CTRL, 32'h100 | (i << 12));
            @(posedge clk_sys) protReq <= 7'h01;
            relayIs(1'b1);
            @(posedge clk_sys) protReq <= 7'h00;
            @(posedge clk_sys) ackReq <= ~(8'h01 << i);
            repeat (10) @(posedge clk_sys);
            check({31'h0, relayDrive}, 32'h1);
            rd(`ROC_OFS_STATUS, 32'h0000000E);
            @(posedge clk_sys) ackReq <= 8'h01 << i;
            relayIs(1'b0);
            @(posedge clk_sys) ackReq <= 8'h00;
        end
        check({24'h0, pickups}, {24'h0, p0 + 8'h08});
        wr(`ROC_OFS_CTRL, 32'h5000);
        @(posedge clk_sys) protReq <= 7'h01;
        relayIs(1'b1);
        @(posedge clk_sys) ackReq <= 8'h20;
        repeat (10) @(posedge clk_sys);
        check({31'h0, relayDrive}, 32'h1);
        @(posedge clk_sys) resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(`ROC_OFS_CTRL, `ROC_CTRL_RESET);
        repeat (6) @(posedge clk_sys);
        check({31'h0, relayDrive}, 32'h0);
        wrap_up;
    end
endmodule

//--- tb/roc_conditioner_sva.sv
// Port checker of the relay output conditioner.
`timescale 1ns/100ps
module roc_conditioner_sva #(
    parameter TICK_CYCLES = 4
) (
    // Clock and reset
    input wire        clk_sys,
    input wire        resetn,
    // Relay drive
    input wire        relayDrive,
    // Register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Nothing is assigned or inverted until software has written once.
    reg wrSeen;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) wrSeen <= 1'b0;
        else if (s_axi_bvalid) wrSeen <= 1'b1;
    end

    sequence s_wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence

    property p_wrAns; s_wrTake |=> s_axi_bvalid; endproperty
    a_wrAns: assert property (p_wrAns) else $error("write not answered");
    property p_bStand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bStand: assert property (p_bStand) else $error("write response dropped");
    property p_bBlock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_bBlock: assert property (p_bBlock) else $error("write taken while answering");
    property p_rdAns; s_rdTake |=> s_axi_rvalid; endproperty
    a_rdAns: assert property (p_rdAns) else $error("read not answered");
    property p_rStand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rStand: assert property (p_rStand) else $error("read data dropped");
    property p_rBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rBlock: assert property (p_rBlock) else $error("read taken while answering");
    property p_idle; $rose(resetn) |-> !relayDrive && !s_axi_bvalid && !s_axi_rvalid; endproperty
    a_idle: assert property (p_idle) else $error("outputs active after reset");
    property p_noCfg; !wrSeen |-> !relayDrive; endproperty
    a_noCfg: assert property (p_noCfg) else $error("relay driven with no slot assigned");
endmodule

bind roc_conditioner roc_conditioner_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
    .clk_sys(clk_sys), .resetn(resetn), .relayDrive(relayDrive),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- tb/roc_field_model.sv
// Field side model: protection and acknowledgement sources, relay pickup counter.
`timescale 1ns/100ps
module roc_field_model (
    // Clock
    input  wire       clk_sys,
    // Bench commands
    input  wire [6:0] protReq,
    input  wire [7:0] ackReq,
    // Device pins
    output reg  [6:0] protSignal,
    output reg  [7:0] ackSource,
    input  wire       relayDrive,
    output reg  [7:0] pickups
);
    reg lastDrive;
    initial begin
        protSignal = 7'h00;
        ackSource  = 8'h00;
        pickups    = 8'h00;
        lastDrive  = 1'b0;
    end
    // Counting pickups exposes a latch that chatters instead of holding.
    always @(posedge clk_sys) begin
        protSignal <= protReq;
        ackSource  <= ackReq;
        lastDrive  <= relayDrive;
        if (relayDrive && !lastDrive) pickups <= pickups + 8'h01;
    end
endmodule
